// ### rtl/bit_addr_defs.vh
`ifndef BIT_ADDR_DEFS_VH
`define BIT_ADDR_DEFS_VH

// =====================================================================
// Pointer geometry
`define PTR_W        23
`define WORD_W       16
`define HIGH_W       7
`define LONG_OFS_W   16
`define SHORT_OFS_W  3
`define SHORT_OFS_MIN 3'h1

// =====================================================================
// Addressing-form codes on mode_sel
`define MODE_W        3
`define MODE_AUX_LONG 3'h0
`define MODE_AUX_PRE  3'h1
`define MODE_AUX_SHORT 3'h2
`define MODE_COEF     3'h3
`define MODE_COEF_INC 3'h4

// =====================================================================
// Operation codes on op_sel
`define OP_W          2
`define OP_SET        2'h0
`define OP_CLR        2'h1
`define OP_PAIR_TEST  2'h2

// =====================================================================
// Status register zero flag positions, post-increment steps
`define ST0_W         16
`define ST0_TEST_FIRST  13
`define ST0_TEST_SECOND 12
`define STEP_SINGLE   23'h000001
`define STEP_PAIR     23'h000002
`define ACC_RESET     40'h0000000000
`define PTR_RESET     23'h000000

`endif

// ### rtl/bit_addr_calc.v
`timescale 1ns/1ps
`default_nettype none
`include "bit_addr_defs.vh"

// Combines pointer high part with the low-word sum of start, word, offset
module bit_addr_calc
(
	// Pointer and operands
	input  wire [`PTR_W-1:0]  ptr_ext,
	input  wire [`WORD_W-1:0] buf_start,
	input  wire               circ_en,
	input  wire [`PTR_W-1:0]  offset,
	// Result
	output wire [`PTR_W-1:0]  bit_addr
);

	wire [`PTR_W-1:0] start_ext;    // Sign-extended buffer start
	wire [`PTR_W-1:0] low_sum;      // Start + word + offset

	// Circular start joins the sum only when enabled
	assign start_ext = circ_en ?
		{{(`PTR_W-`WORD_W){buf_start[`WORD_W-1]}}, buf_start} :
		`PTR_RESET;
	assign low_sum = start_ext +
		{{(`PTR_W-`WORD_W){1'b0}}, ptr_ext[`WORD_W-1:0]} + offset;
	// Upper part from the pointer, low word from the sum
	assign bit_addr = {ptr_ext[`PTR_W-1:`WORD_W],
		low_sum[`WORD_W-1:0]};

endmodule
`default_nettype wire

// ### rtl/register_bit_address_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "bit_addr_defs.vh"

module register_bit_address_gen
#(
	parameter ACC_W = 40
)
(
	// Clock and reset
	input  wire                    core_clk,
	input  wire                    resetn,
	// Instruction from the decoder
	input  wire                    instr_valid,
	input  wire [`MODE_W-1:0]      mode_sel,
	input  wire [`OP_W-1:0]        op_sel,
	input  wire                    acc_sel,
	input  wire                    parallel_req,
	input  wire [7:0]              ext_byte_hi,
	input  wire [7:0]              ext_byte_lo,
	input  wire [`SHORT_OFS_W-1:0] short_offset_const,
	// Circular configuration
	input  wire                    aux_circ_en,
	input  wire                    coef_circ_en,
	input  wire [`WORD_W-1:0]      aux_buffer_start,
	input  wire [`WORD_W-1:0]      coef_buffer_start,
	// Pointer loads from elsewhere in the CPU
	input  wire                    aux_load,
	input  wire [`PTR_W-1:0]       aux_load_val,
	input  wire                    coef_high_load,
	input  wire [`HIGH_W-1:0]      coef_high_val,
	input  wire                    coef_word_load,
	input  wire [`WORD_W-1:0]      coef_word_val,
	// Accumulator loads
	input  wire                    acc_load,
	input  wire [ACC_W-1:0]        acc_load_val,
	// Results
	output wire                    parallel_ok,
	output wire                    illegal_offset,
	output reg  [`PTR_W-1:0]       bit_addr_r,
	output reg  [`PTR_W-1:0]       aux_pointer_extended,
	output wire [`PTR_W-1:0]       coef_pointer_full,
	output reg  [ACC_W-1:0]        accumulator_two,
	output reg  [ACC_W-1:0]        accumulator_three,
	output reg  [`ST0_W-1:0]       status_reg_zero
);

	// =================================================================
	// Pointer state
	reg  [`HIGH_W-1:0] coef_pointer_high;   // Upper seven bits
	reg  [`WORD_W-1:0] coef_pointer_word;   // Lower sixteen bits
	wire [`WORD_W-1:0] aux_pointer_word;    // Low word of aux pointer
	wire [`WORD_W-1:0] long_offset_const;   // From the 2-byte extension
	wire [`PTR_W-1:0]  long_ext;            // Sign-extended long offset
	wire [`PTR_W-1:0]  short_ext;           // Zero-extended short offset
	wire               long_form;           // Form uses the extension
	wire               is_aux;              // Aux pointer family
	reg  [`PTR_W-1:0]  calc_ptr;            // Pointer fed to address
	reg  [`PTR_W-1:0]  calc_ofs;            // Offset fed to address
	reg  [`PTR_W-1:0]  aux_nxt;             // Aux pointer next value
	reg  [`PTR_W-1:0]  coef_nxt;            // Coef pointer next value
	wire [`PTR_W-1:0]  bit_addr;            // Generated address
	wire [ACC_W-1:0]   acc_src;             // Selected accumulator
	reg  [ACC_W-1:0]   acc_nxt;             // Modified accumulator
	wire               do_op;               // Accepted instruction

	// Index into the accumulator, wrapped to the accumulator width
	function [ACC_W-1:0] bit_mask;
		input [`PTR_W-1:0] addr;
		begin
			bit_mask = {{(ACC_W-1){1'b0}}, 1'b1} << (addr % ACC_W);
		end
	endfunction

	function acc_bit;
		input [ACC_W-1:0] acc;
		input [`PTR_W-1:0] addr;
		begin
			acc_bit = |(acc & bit_mask(addr));
		end
	endfunction

	// =================================================================
	// Operand forming
	assign coef_pointer_full = {coef_pointer_high, coef_pointer_word};
	assign aux_pointer_word  = aux_pointer_extended[`WORD_W-1:0];
	assign long_offset_const = {ext_byte_hi, ext_byte_lo};
	assign long_ext  = {{(`PTR_W-`LONG_OFS_W){long_offset_const[`LONG_OFS_W-1]}},
		long_offset_const};
	assign short_ext = {{(`PTR_W-`SHORT_OFS_W){1'b0}},
		short_offset_const};
	assign long_form = (mode_sel == `MODE_AUX_LONG) ||
		(mode_sel == `MODE_AUX_PRE);
	assign is_aux = long_form || (mode_sel == `MODE_AUX_SHORT);
	// Long-offset forms may not issue alongside another instruction
	assign parallel_ok = instr_valid && !long_form;
	assign illegal_offset = instr_valid &&
		(mode_sel == `MODE_AUX_SHORT) &&
		(short_offset_const < `SHORT_OFS_MIN);
	assign do_op = instr_valid && !(long_form && parallel_req);
	assign acc_src = acc_sel ? accumulator_three : accumulator_two;

	// =================================================================
	// Select pointer, offset and next pointer values per form
	always @*
	begin
		calc_ptr = coef_pointer_full;
		calc_ofs = `PTR_RESET;
		aux_nxt  = aux_pointer_extended;
		coef_nxt = coef_pointer_full;
		case (mode_sel)
			`MODE_AUX_LONG:
			begin
				// Base pointer kept
				calc_ptr = aux_pointer_extended;
				calc_ofs = long_ext;
			end
			`MODE_AUX_PRE:
			begin
				// Add first, then address from updated pointer
				aux_nxt  = aux_pointer_extended + long_ext;
				calc_ptr = aux_nxt;
			end
			`MODE_AUX_SHORT:
			begin
				calc_ptr = aux_pointer_extended;
				calc_ofs = short_ext;
			end
			`MODE_COEF:
			begin
				// Pointer kept unchanged
				calc_ptr = coef_pointer_full;
			end
			`MODE_COEF_INC:
			begin
				// Step by the number of bits used
				coef_nxt = coef_pointer_full +
					((op_sel == `OP_PAIR_TEST) ?
					`STEP_PAIR : `STEP_SINGLE);
			end
			default:
			begin
				calc_ptr = coef_pointer_full;
			end
		endcase
	end

	bit_addr_calc u_calc
	(
		.ptr_ext   (calc_ptr),
		.buf_start (is_aux ? aux_buffer_start : coef_buffer_start),
		.circ_en   (is_aux ? aux_circ_en : coef_circ_en),
		.offset    (calc_ofs),
		.bit_addr  (bit_addr)
	);

	// =================================================================
	// Accumulator bit modification
	always @*
	begin
		acc_nxt = acc_src;
		case (op_sel)
			`OP_SET:  acc_nxt = acc_src | bit_mask(bit_addr);
			`OP_CLR:  acc_nxt = acc_src & ~bit_mask(bit_addr);
			default:  acc_nxt = acc_src;
		endcase
	end

	// =================================================================
	// State update, by the consuming instruction or else by external loads
	always @(posedge core_clk)
	begin
		if (!resetn)
		begin
			aux_pointer_extended <= `PTR_RESET;
			coef_pointer_high    <= {`HIGH_W{1'b0}};
			coef_pointer_word    <= {`WORD_W{1'b0}};
			accumulator_two      <= `ACC_RESET;
			accumulator_three    <= `ACC_RESET;
			status_reg_zero      <= {`ST0_W{1'b0}};
			bit_addr_r           <= `PTR_RESET;
		end
		else
		begin
			// Pointer writes from the decoder path
			if (do_op && !illegal_offset)
			begin
				aux_pointer_extended <= aux_nxt;
				coef_pointer_high    <= coef_nxt[`PTR_W-1:`WORD_W];
				coef_pointer_word    <= coef_nxt[`WORD_W-1:0];
				bit_addr_r           <= bit_addr;
				if (op_sel == `OP_PAIR_TEST)
				begin
					status_reg_zero[`ST0_TEST_FIRST] <=
						acc_bit(acc_src, bit_addr);
					status_reg_zero[`ST0_TEST_SECOND] <=
						acc_bit(acc_src, bit_addr + `STEP_SINGLE);
				end
				else if (acc_sel)
					accumulator_three <= acc_nxt;
				else
					accumulator_two <= acc_nxt;
			end
			else
			begin
				// External loads when no instruction is consuming
				if (aux_load)
					aux_pointer_extended <= aux_load_val;
				if (coef_high_load)
					coef_pointer_high <= coef_high_val;
				if (coef_word_load)
					coef_pointer_word <= coef_word_val;
				if (acc_load && acc_sel)
					accumulator_three <= acc_load_val;
				if (acc_load && !acc_sel)
					accumulator_two <= acc_load_val;
			end
		end
	end

endmodule
`default_nettype wire

// ### verif/register_bit_address_gen_props.sv
`timescale 1ns/1ps
`default_nettype none
module bit_addr_props
#(
	parameter ACC_W = 40
)
(
	// Clock and reset
	input wire logic	core_clk,
	input wire logic	resetn,
	// Instruction and circular setup
	input wire logic	instr_valid,
	input wire logic [2:0]	mode_sel,
	input wire logic [1:0]	op_sel,
	input wire logic	acc_sel,
	input wire logic	parallel_req,
	input wire logic [7:0]	ext_byte_hi,
	input wire logic [7:0]	ext_byte_lo,
	input wire logic [2:0]	short_offset_const,
	input wire logic	aux_circ_en,
	input wire logic	coef_circ_en,
	input wire logic [15:0]	coef_buffer_start,
	// Results
	input wire logic	parallel_ok,
	input wire logic	illegal_offset,
	input wire logic [22:0]	bit_addr_r,
	input wire logic [22:0]	aux_pointer_extended,
	input wire logic [22:0]	coef_pointer_full,
	input wire logic [ACC_W-1:0]	accumulator_two,
	input wire logic [15:0]	status_reg_zero
);
	// ==========================================
	// Helpers: acceptance and expected addresses
	wire	lng = mode_sel < 3'h2;
	wire	tk = instr_valid && !illegal_offset && !(lng && parallel_req);
	wire [15:0]	k = {ext_byte_hi, ext_byte_lo};
	wire [22:0]	ap = aux_pointer_extended;
	wire [22:0]	cp = coef_pointer_full;
	wire [22:0]	long_a = {ap[22:16], ap[15:0] + k};
	wire [22:0]	pre_p = ap + {{7{k[15]}}, k};
	wire [22:0]	short_a = {ap[22:16], ap[15:0] + {13'h0, short_offset_const}};
	wire [22:0]	circ_a = {cp[22:16], cp[15:0] + coef_buffer_start};
	wire [22:0]	step_p = cp + ((op_sel == 2'h2) ? 23'h2 : 23'h1);
	wire [5:0]	bi = 6'(bit_addr_r % ACC_W);
	wire [22:0]	nxt_a = bit_addr_r + 23'h1;
	wire [5:0]	bj = 6'(nxt_a % ACC_W);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Pre-add step: offset lands in pointer first
	sequence s_pre;
		tk && mode_sel == 3'h1 && !aux_circ_en;
	endsequence
	// ==========================================
	// Properties
	a_long_no_pair: assert property (instr_valid && lng |-> !parallel_ok)
		else $error("long form pairable");
	a_short_pairable: assert property (instr_valid && !lng |-> parallel_ok)
		else $error("short form not pairable");
	a_legal_offset: assert property (!(mode_sel == 3'h2 &&
		short_offset_const == 3'h0) |-> !illegal_offset) else $error("k legal");
	a_short_zero: assert property (instr_valid && mode_sel == 3'h2 &&
		short_offset_const == 3'h0 |-> illegal_offset) else $error("k zero");
	a_long_addr: assert property (tk && mode_sel == 3'h0 && !aux_circ_en |=>
		bit_addr_r == $past(long_a) && $stable(ap)) else $error("long addr");
	a_pre_add_wb: assert property (s_pre |=> ap == $past(pre_p) &&
		bit_addr_r == ap) else $error("pre-add");
	a_short_addr: assert property (tk && mode_sel == 3'h2 && !aux_circ_en |=>
		bit_addr_r == $past(short_a) && $stable(ap)) else $error("short addr");
	a_coef_plain: assert property (tk && mode_sel == 3'h3 && !coef_circ_en |=>
		bit_addr_r == $past(cp) && $stable(cp)) else $error("coef plain");
	a_circ_start: assert property (tk && mode_sel == 3'h3 && coef_circ_en |=>
		bit_addr_r == $past(circ_a)) else $error("circ start");
	a_post_step: assert property (tk && mode_sel == 3'h4 && op_sel != 2'h3 |=>
		cp == $past(step_p)) else $error("post step");
	a_pair_flags: assert property (tk && op_sel == 2'h2 && !acc_sel |=>
		status_reg_zero[13] == accumulator_two[bi] &&
		status_reg_zero[12] == accumulator_two[bj]) else $error("pair");
	a_set_clear: assert property (tk && op_sel < 2'h2 && !acc_sel |=>
		accumulator_two[bi] == ($past(op_sel) == 2'h0)) else $error("set clr");
endmodule
bind register_bit_address_gen bit_addr_props #(.ACC_W(ACC_W)) u_props (.core_clk,
	.resetn, .instr_valid, .mode_sel, .op_sel, .acc_sel, .parallel_req,
	.ext_byte_hi, .ext_byte_lo, .short_offset_const, .aux_circ_en,
	.coef_circ_en, .coef_buffer_start, .parallel_ok, .illegal_offset,
	.bit_addr_r, .aux_pointer_extended, .coef_pointer_full, .accumulator_two,
	.status_reg_zero);
`default_nettype wire

// ### verif/register_bit_address_gen_bench.sv
`timescale 1ns/1ps
`default_nettype none
module register_bit_address_gen_bench;
	// ==========================================
	// Inputs, outputs and reference state
	logic	core_clk = '0, resetn = '0, instr_valid = '0, acc_sel = '0;
	logic	parallel_req = '0, aux_circ_en = '0, coef_circ_en = '0;
	logic	aux_load = '0, coef_high_load = '0, coef_word_load = '0;
	logic	acc_load = '0;
	logic [2:0]	mode_sel = '0, short_offset_const = '0;
	logic [1:0]	op_sel = '0, m_f = '0;
	logic [7:0]	ext_byte_hi = '0, ext_byte_lo = '0;
	logic [6:0]	coef_high_val = '0;
	logic [15:0]	aux_buffer_start = '0, coef_buffer_start = '0;
	logic [15:0]	coef_word_val = '0;
	logic [22:0]	aux_load_val = '0, m_aux = '0, m_coef = '0, m_ba = '0;
	logic [39:0]	acc_load_val = '0;
	logic [39:0]	m_acc [2] = '{40'h0, 40'h0};
	logic [150:0]	q [$];
	int	seed = 32'h6BD6875C, n_fail = 0, checked = 0;
	wire	parallel_ok, illegal_offset;
	wire [22:0]	bit_addr_r, aux_pointer_extended, coef_pointer_full;
	wire [39:0]	accumulator_two, accumulator_three;
	wire [15:0]	status_reg_zero;
	wire [150:0]	seen_w = {bit_addr_r, aux_pointer_extended,
		coef_pointer_full, accumulator_two, accumulator_three,
		status_reg_zero[13], status_reg_zero[12]};
	register_bit_address_gen uut (.core_clk, .resetn, .instr_valid, .mode_sel,
		.op_sel, .acc_sel, .parallel_req, .ext_byte_hi, .ext_byte_lo,
		.short_offset_const, .aux_circ_en, .coef_circ_en, .aux_buffer_start,
		.coef_buffer_start, .aux_load, .aux_load_val, .coef_high_load,
		.coef_high_val, .coef_word_load, .coef_word_val, .acc_load,
		.acc_load_val, .parallel_ok, .illegal_offset, .bit_addr_r,
		.aux_pointer_extended, .coef_pointer_full, .accumulator_two,
		.accumulator_three, .status_reg_zero);
	// ==========================================
	// Clock, compare and verdict
	initial forever #10 core_clk = ~core_clk;
	task check(input logic [150:0] seen, input logic [150:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask
	task finish_test;
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Oldest note meets settled registers
	always @(negedge core_clk)
		if (q.size() > 0)
			check(seen_w, q.pop_front());
	// ==========================================
	// Drivers: pointer/accumulator load, one instruction
	task ld(input logic a, input logic [22:0] x, y, input logic [39:0] v);
		{instr_valid, acc_sel, aux_load_val, acc_load_val} <= {1'h0, a, x, v};
		{coef_high_val, coef_word_val} <= y;
		{aux_load, coef_high_load, coef_word_load, acc_load} <= 4'hF;
		@(posedge core_clk);
		{aux_load, coef_high_load, coef_word_load, acc_load} <= 4'h0;
		@(posedge core_clk);
		{m_aux, m_coef, m_acc[a]} = {x, y, v};
	endtask
	task op(input logic [2:0] m, input logic [1:0] o, input logic a, p, c,
		input logic [15:0] k, bs, input logic [2:0] k3);
		logic [22:0] ofs;
		logic [22:0] ptr;
		logic [5:0] i;
		logic [22:0] nb;
		{mode_sel, op_sel, acc_sel, parallel_req, aux_circ_en} <= {m, o, a, p, c};
		{coef_circ_en, ext_byte_hi, ext_byte_lo, short_offset_const} <= {c, k, k3};
		{aux_buffer_start, coef_buffer_start, instr_valid} <= {bs, bs, 1'h1};
		@(posedge core_clk);
		if (!((m < 3'h2 && p) || (m == 3'h2 && k3 == 3'h0)))
		begin
			ofs = (m == 3'h2) ? {20'h0, k3} : {{7{k[15]}}, k};
			ptr = (m > 3'h2) ? m_coef : m_aux;
			if (m == 3'h1)
				m_aux = ptr + ofs;
			if (m == 3'h1)
				ptr = m_aux;
			if (m == 3'h1 || m > 3'h2)
				ofs = 23'h0;
			m_ba = {ptr[22:16], ptr[15:0] + (c ? bs : 16'h0) + ofs[15:0]};
			if (m == 3'h4)
				m_coef = m_coef + ((o == 2'h2) ? 23'h2 : 23'h1);
			i = 6'(m_ba % 40);
			nb = m_ba + 23'h1;
			if (o == 2'h2)
				m_f = {m_acc[a][i], m_acc[a][6'(nb % 40)]};
			else if (o != 2'h3)
				m_acc[a][i] = (o == 2'h0);
		end
		q.push_back({m_ba, m_aux, m_coef, m_acc[0], m_acc[1], m_f});
	endtask
	// ==========================================
	// Sequence: reset values, one post-step paired test, random mix
	initial
	begin
		repeat (12) @(posedge core_clk);
		q.push_back(151'h0);
		resetn <= 1'h1;
		ld(1'h0, 23'h1E, 23'h1E, 40'hC0000000);
		op(3'h4, 2'h2, 1'h0, 1'h0, 1'h0, 16'h0, 16'h0, 3'h1);
		for (int n = 0; n < 400; n++)
		begin
			if (n % 25 == 0)
				ld(n % 2, $random(seed), $random(seed), {$random(seed), $random(seed)});
			op({$random(seed)} % 8, {$random(seed)} % 4, $random(seed),
				$random(seed), $random(seed), $random(seed), $random(seed),
				$random(seed));
		end
		instr_valid <= 1'h0;
		repeat (3) @(posedge core_clk);
		finish_test();
	end
endmodule
`default_nettype wire
